// ==== core/rms_pkg.sv ====
// Operation
// - Reset low clears state, device stays dormant.
// - Reset input passes through internal synchronizer.
// - First fetch about seven cycles after release.
// - System reset output synchronous, tracks input length.
// - System reset drops two clocks after release.
// - System reset output driven during bus hold.
// - Enhanced only if strap high then low.
// - System reset tied to strap gives enhanced.
// - Mode strap input during reset, weak pull-up.
// - Both selects low at release floats pins.
// - Lower select pull-up only during reset.
// - Read strobe tied low selects queue status.
// - Mid selects zero, one pulled up in reset.
// - Refresh high compatible, floats in reset, hold.
// - Lock pull-up during reset and bus hold.
// - Upper select pull-up active during reset.
// - Clock output toggles through reset and hold.
`default_nettype none
package rms_pkg;
  localparam int  CLK_PERIOD_NS      = 25;
  // Release to deassert of system reset output, in clocks.
  localparam int  RESET_OUT_CLOCKS   = 2;
  // Strap is checked this many clocks after the system reset output drops.
  localparam int  STRAP_DELAY_CLOCKS = 4;
  // Fetch start, six and a half clocks rounded up to whole clocks.
  localparam int  FETCH_HALF_CLOCKS  = 13;
  localparam int  FETCH_CLOCKS       = (FETCH_HALF_CLOCKS + 1) / 2;
  localparam int  CNT_W              = 3;
  localparam logic [CNT_W-1:0] STRAP_CNT = CNT_W'(STRAP_DELAY_CLOCKS);
  localparam logic [CNT_W-1:0] FETCH_CNT = CNT_W'(FETCH_CLOCKS - RESET_OUT_CLOCKS);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;

  typedef enum logic [1:0] {
    RMS_RESET  = 2'b00,
    RMS_STRAP  = 2'b01,
    RMS_START  = 2'b10,
    RMS_RUN    = 2'b11
  } rms_state_t;
endpackage
`default_nettype wire

// ==== core/rms_reset_mode.sv ====
`default_nettype none
module rms_reset_mode
  import rms_pkg::*;
(
  // Clock and reset
  input  wire logic CLK,
  input  wire logic NRST,
  // Board reset and strap pins
  input  wire logic POWER_ON_CLEAR_IN_N,
  input  wire logic MODE_STRAP_IN,
  input  wire logic UPPER_MEMORY_SELECT_N_IN,
  input  wire logic LOWER_MEMORY_SELECT_N_IN,
  input  wire logic READ_STROBE_QUEUE_STRAP_N_IN,
  // Bus hold and refresh request from the core
  input  wire logic BUS_HOLD,
  input  wire logic REFRESH_REQ,
  // System reset and clock outputs
  output logic      SYSTEM_RESET,
  output logic      SYSTEM_CLOCK_OUT,
  output logic      FETCH_START,
  output logic      CORE_RUN,
  // Latched modes
  output logic      ENHANCED_MODE,
  output logic      FLOAT_TEST_MODE,
  output logic      QUEUE_STATUS_MODE,
  // Pin control, enables active low while driving
  output logic      REFRESH_CYCLE_N,
  output logic      REFRESH_CYCLE_OE_N,
  output logic      PIN_FLOAT_ALL,
  output logic      MODE_STRAP_PULLUP,
  output logic      UPPER_SELECT_PULLUP,
  output logic      LOWER_SELECT_PULLUP,
  output logic      READ_STROBE_PULLUP,
  output logic      MID_SELECT_PULLUP,
  output logic      LOCK_PULLUP
);
  import rms_pkg::*;

  // ------------------------------------------------------------
  // Reset synchronizer
  // ------------------------------------------------------------
  logic             sync_a;
  logic             sync_b;
  logic             res_q;
  rms_state_t       state;
  rms_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             strap_at_rise;
  logic             in_reset;
  logic             rise;
  logic             strap_done;
  logic             start_done;

  // The raw pin is asynchronous, so only the second and third stages are used.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      res_q  <= 1'b0;
    end else begin
      sync_a <= POWER_ON_CLEAR_IN_N;
      sync_b <= sync_a;
      res_q  <= sync_b;
    end
  end

  assign rise       = sync_b & ~res_q;
  assign in_reset   = ~sync_b;
  assign strap_done = (state == RMS_STRAP) && (cnt == STRAP_CNT);
  assign start_done = (state == RMS_START) && (cnt == FETCH_CNT);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = cnt + 3'h1;
    case (state)
      RMS_RESET: begin
        next_cnt = CNT_ZERO;
        if (rise) begin
          next_state = RMS_STRAP;
          next_cnt   = 3'h1;
        end
      end
      RMS_STRAP: begin
        if (strap_done) begin
          next_state = RMS_START;
        end
      end
      // The fetch count is reached on entry, so this state lasts one clock.
      RMS_START: begin
        if (start_done) begin
          next_state = RMS_RUN;
        end
      end
      RMS_RUN:   next_cnt = cnt;
      default:   next_state = RMS_RESET;
    endcase
    if (in_reset) begin
      next_state = RMS_RESET;
      next_cnt   = CNT_ZERO;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= RMS_RESET;
      cnt   <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // ------------------------------------------------------------
  // Outputs and mode latches
  // ------------------------------------------------------------
  // Modes settle at least one clock before the fetch pulse, so the core never
  // starts its first fetch under a stale mode selection.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SYSTEM_RESET       <= 1'b1;
      SYSTEM_CLOCK_OUT   <= 1'b0;
      FETCH_START        <= 1'b0;
      CORE_RUN           <= 1'b0;
      strap_at_rise      <= 1'b0;
      ENHANCED_MODE      <= 1'b0;
      FLOAT_TEST_MODE    <= 1'b0;
      QUEUE_STATUS_MODE  <= 1'b0;
      REFRESH_CYCLE_N    <= 1'b1;
      REFRESH_CYCLE_OE_N <= 1'b1;
      PIN_FLOAT_ALL      <= 1'b0;
    end else begin
      SYSTEM_CLOCK_OUT <= ~SYSTEM_CLOCK_OUT;
      // Deasserts one edge after the second stage sees the release, so a
      // strap tied to this output still reads high when it is first sampled.
      SYSTEM_RESET     <= ~sync_b;
      FETCH_START      <= start_done & ~in_reset;
      CORE_RUN         <= in_reset ? 1'b0 : (CORE_RUN | start_done);
      if (in_reset) begin
        ENHANCED_MODE     <= 1'b0;
        QUEUE_STATUS_MODE <= 1'b0;
        FLOAT_TEST_MODE   <= 1'b0;
        PIN_FLOAT_ALL     <= 1'b0;
      end else if (rise && state == RMS_RESET) begin
        strap_at_rise   <= MODE_STRAP_IN;
        FLOAT_TEST_MODE <= ~UPPER_MEMORY_SELECT_N_IN & ~LOWER_MEMORY_SELECT_N_IN;
        PIN_FLOAT_ALL   <= ~UPPER_MEMORY_SELECT_N_IN & ~LOWER_MEMORY_SELECT_N_IN;
        QUEUE_STATUS_MODE <= ~READ_STROBE_QUEUE_STRAP_N_IN;
      end else if (strap_done) begin
        ENHANCED_MODE <= strap_at_rise & ~MODE_STRAP_IN;
      end
      REFRESH_CYCLE_N    <= ENHANCED_MODE ? ~REFRESH_REQ : 1'b1;
      REFRESH_CYCLE_OE_N <= in_reset | BUS_HOLD | PIN_FLOAT_ALL;
    end
  end

  // Pull-ups other than mode strap follow the synchronized reset (lock also hold); strap pins read high if open.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MODE_STRAP_PULLUP   <= 1'b1;
      UPPER_SELECT_PULLUP <= 1'b1;
      LOWER_SELECT_PULLUP <= 1'b1;
      READ_STROBE_PULLUP  <= 1'b1;
      MID_SELECT_PULLUP   <= 1'b1;
      LOCK_PULLUP         <= 1'b1;
    end else begin
      MODE_STRAP_PULLUP   <= 1'b1;
      UPPER_SELECT_PULLUP <= ~sync_b;
      LOWER_SELECT_PULLUP <= ~sync_b;
      READ_STROBE_PULLUP  <= ~sync_b;
      MID_SELECT_PULLUP   <= ~sync_b;
      LOCK_PULLUP         <= ~sync_b | BUS_HOLD;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Internal sequencer signals are watched directly; the bench sees only ports.
  reset_release_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(sync_b) |=> !SYSTEM_RESET) else $error("system reset did not drop after release");
  reset_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    !sync_b |=> SYSTEM_RESET) else $error("system reset low while input low");
  fetch_delay_a: assert property (@(posedge CLK) disable iff (!NRST)
    (rise && state == RMS_RESET) ##1 (!in_reset)[*5] |=> FETCH_START) else $error("fetch start late");
  dormant_a: assert property (@(posedge CLK) disable iff (!NRST)
    in_reset |=> !CORE_RUN && !ENHANCED_MODE) else $error("core active in reset");
  enhanced_sel_a: assert property (@(posedge CLK) disable iff (!NRST)
    strap_done |=> ENHANCED_MODE == (strap_at_rise && !$past(MODE_STRAP_IN))) else $error("mode select wrong");
  float_sel_a: assert property (@(posedge CLK) disable iff (!NRST)
    (rise && state == RMS_RESET && !UPPER_MEMORY_SELECT_N_IN && !LOWER_MEMORY_SELECT_N_IN && !in_reset)
      |=> PIN_FLOAT_ALL) else $error("float test not entered");
  mode_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    (state == RMS_RUN && !in_reset && $past(state) == RMS_RUN) |=> $stable(QUEUE_STATUS_MODE))
    else $error("mode changed while running");
  refresh_float_a: assert property (@(posedge CLK) disable iff (!NRST)
    (in_reset || BUS_HOLD) |=> REFRESH_CYCLE_OE_N) else $error("refresh driven in reset or hold");
  lock_pull_a: assert property (@(posedge CLK) disable iff (!NRST)
    BUS_HOLD |=> LOCK_PULLUP) else $error("lock pull-up off in hold");
  clock_run_a: assert property (@(posedge CLK) disable iff (!NRST)
    SYSTEM_CLOCK_OUT |=> !SYSTEM_CLOCK_OUT) else $error("clock output stalled");
  pullup_reset_a: assert property (@(posedge CLK) disable iff (!NRST)
    !sync_b |=> UPPER_SELECT_PULLUP && LOWER_SELECT_PULLUP && MID_SELECT_PULLUP) else $error("pull-up off in reset");
  pullup_off_a: assert property (@(posedge CLK) disable iff (!NRST)
    sync_b |=> !LOWER_SELECT_PULLUP && !READ_STROBE_PULLUP) else $error("pull-up left on after reset");
  fetch_once_a: assert property (@(posedge CLK) disable iff (!NRST)
    FETCH_START |=> !FETCH_START) else $error("fetch start longer than one clock");
  refresh_compat_a: assert property (@(posedge CLK) disable iff (!NRST)
    !ENHANCED_MODE |=> REFRESH_CYCLE_N) else $error("refresh low in compatible mode");
  float_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    (state == RMS_RUN && !in_reset) |=> $stable(PIN_FLOAT_ALL)) else $error("float mode changed while running");

  // Main scenarios: enhanced, float test, queue status, fetch and hold.
  enh_cover: cover property (@(posedge CLK) disable iff (!NRST) $rose(ENHANCED_MODE));
  float_cover: cover property (@(posedge CLK) disable iff (!NRST) $rose(PIN_FLOAT_ALL));
  fetch_cover: cover property (@(posedge CLK) disable iff (!NRST) FETCH_START);
  queue_cover: cover property (@(posedge CLK) disable iff (!NRST) $rose(QUEUE_STATUS_MODE));
  hold_cover: cover property (@(posedge CLK) disable iff (!NRST) BUS_HOLD && CORE_RUN);
endmodule
`default_nettype wire

// ==== bench/rms_board.sv ====
`default_nettype none
// -----------------------------------------------------------------
// Board reset circuit and mode strap wiring
// -----------------------------------------------------------------
module rms_board (
  // Clock and bench controls
  input  wire logic       CLK,
  input  wire logic       fire,
  input  wire logic [3:0] len,
  input  wire logic       tie,
  input  wire logic       open,
  input  wire logic       level,
  // Device side
  input  wire logic       SYSTEM_RESET,
  input  wire logic       MODE_STRAP_PULLUP,
  output logic            POWER_ON_CLEAR_IN_N,
  output logic            MODE_STRAP_IN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt = 4'h0;
  // The pulse always spans more than four stable clocks.
  always @(negedge CLK) begin
    if (fire) begin
      cnt <= len;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign POWER_ON_CLEAR_IN_N = (cnt == 4'h0);
  // An open strap shows the wrong level unless the weak pull-up holds it.
  assign MODE_STRAP_IN = tie ? SYSTEM_RESET : (open ? (MODE_STRAP_PULLUP | ~level) : level);
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK, NRST, POWER_ON_CLEAR_IN_N, MODE_STRAP_IN, UPPER_MEMORY_SELECT_N_IN, LOWER_MEMORY_SELECT_N_IN;
  logic READ_STROBE_QUEUE_STRAP_N_IN, BUS_HOLD, REFRESH_REQ, SYSTEM_RESET, SYSTEM_CLOCK_OUT, FETCH_START;
  logic CORE_RUN, ENHANCED_MODE, FLOAT_TEST_MODE, QUEUE_STATUS_MODE, REFRESH_CYCLE_N, REFRESH_CYCLE_OE_N;
  logic PIN_FLOAT_ALL, MODE_STRAP_PULLUP, UPPER_SELECT_PULLUP, LOWER_SELECT_PULLUP, READ_STROBE_PULLUP;
  logic MID_SELECT_PULLUP, LOCK_PULLUP, fire, tie, open, level;
  logic [3:0]  len;
  logic [31:0] r = 32'h1BD7;
  int n_mismatch = 0;
  int checks_done = 0;
  int fetches = 0;
  rms_reset_mode i_dut (.CLK, .NRST, .POWER_ON_CLEAR_IN_N, .MODE_STRAP_IN, .UPPER_MEMORY_SELECT_N_IN,
    .LOWER_MEMORY_SELECT_N_IN, .READ_STROBE_QUEUE_STRAP_N_IN, .BUS_HOLD, .REFRESH_REQ, .SYSTEM_RESET,
    .SYSTEM_CLOCK_OUT, .FETCH_START, .CORE_RUN, .ENHANCED_MODE, .FLOAT_TEST_MODE, .QUEUE_STATUS_MODE,
    .REFRESH_CYCLE_N, .REFRESH_CYCLE_OE_N, .PIN_FLOAT_ALL, .MODE_STRAP_PULLUP, .UPPER_SELECT_PULLUP,
    .LOWER_SELECT_PULLUP, .READ_STROBE_PULLUP, .MID_SELECT_PULLUP, .LOCK_PULLUP);
  rms_board i_board (.CLK, .fire, .len, .tie, .open, .level, .SYSTEM_RESET, .MODE_STRAP_PULLUP,
    .POWER_ON_CLEAR_IN_N, .MODE_STRAP_IN);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected modes: enhanced, float test, queue status.
  function automatic logic [2:0] exp_modes(input logic rise, late, t, o, u, l, rd);
    return {t | (~o & rise & ~late), ~u & ~l, ~rd};
  endfunction
  task automatic chk(input string name, input logic [4:0] seen, input logic [4:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge CLK) if (FETCH_START === 1'b1) fetches++;
  // One board reset pulse with the given straps, then hold and strap changes.
  task automatic run(input logic rise, late, t, o, u, l, rd, input logic [3:0] n);
    logic [2:0] m;
    logic       co;
    m = exp_modes(rise, late, t, o, u, l, rd);
    @(negedge CLK);
    {level, tie, open, UPPER_MEMORY_SELECT_N_IN} <= {rise, t, o, u};
    {LOWER_MEMORY_SELECT_N_IN, READ_STROBE_QUEUE_STRAP_N_IN, BUS_HOLD, fire, len} <= {l, rd, 2'b01, n};
    @(negedge CLK);
    fire <= 1'b0;
    repeat (n - 4'h1) @(negedge CLK);
    co = SYSTEM_CLOCK_OUT;
    chk("reset state", {SYSTEM_RESET, REFRESH_CYCLE_OE_N, ENHANCED_MODE, FLOAT_TEST_MODE, QUEUE_STATUS_MODE},
      5'h18);
    chk("reset pullups", {UPPER_SELECT_PULLUP, LOWER_SELECT_PULLUP, MID_SELECT_PULLUP, LOCK_PULLUP,
      MODE_STRAP_PULLUP}, 5'h1F);
    @(negedge CLK);
    fetches = 0;
    chk("clock out", {4'h0, SYSTEM_CLOCK_OUT}, {4'h0, ~co});
    @(posedge CLK);
    #1 chk("reset out first", 5'(SYSTEM_RESET), 5'h01);
    @(posedge CLK);
    #1 chk("reset out second", 5'(SYSTEM_RESET), 5'h01);
    @(posedge CLK);
    #1 chk("reset out drop", 5'(SYSTEM_RESET), 5'h00);
    repeat (3) @(negedge CLK);
    level <= late;
    repeat (10) @(negedge CLK);
    chk("fetch count", 5'(fetches), 5'h01);
    chk("core run", {4'h0, CORE_RUN}, 5'h01);
    chk("modes", {ENHANCED_MODE, FLOAT_TEST_MODE, QUEUE_STATUS_MODE}, 5'(m));
    chk("pins", {PIN_FLOAT_ALL, LOWER_SELECT_PULLUP, REFRESH_CYCLE_OE_N}, {m[1], 1'b0, m[1]});
    chk("pullups off", {UPPER_SELECT_PULLUP, MID_SELECT_PULLUP, READ_STROBE_PULLUP, LOCK_PULLUP},
      5'h00);
    if (!m[1]) chk("refresh level", {4'h0, REFRESH_CYCLE_N}, {4'h0, ~(m[2] & REFRESH_REQ)});
    {level, UPPER_MEMORY_SELECT_N_IN, LOWER_MEMORY_SELECT_N_IN, READ_STROBE_QUEUE_STRAP_N_IN} <= {~late, ~u, ~l, ~rd};
    repeat (4) @(negedge CLK);
    chk("modes held", {ENHANCED_MODE, FLOAT_TEST_MODE, QUEUE_STATUS_MODE}, 5'(m));
    BUS_HOLD <= 1'b1;
    repeat (3) @(negedge CLK);
    co = SYSTEM_CLOCK_OUT;
    @(negedge CLK);
    chk("hold", {SYSTEM_RESET, LOCK_PULLUP, REFRESH_CYCLE_OE_N, SYSTEM_CLOCK_OUT}, {2'b01, 1'b1, ~co});
  endtask
  initial begin
    {NRST, fire, len} = {2'b01, 4'h8};
    {tie, open, level, BUS_HOLD, REFRESH_REQ} = 5'h00;
    {UPPER_MEMORY_SELECT_N_IN, LOWER_MEMORY_SELECT_N_IN, READ_STROBE_QUEUE_STRAP_N_IN} = 3'b111;
    repeat (6) @(negedge CLK);
    NRST <= 1'b1;
    fire <= 1'b0;
    run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h6);
    run(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'h7);
    run(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h6);
    for (int i = 0; i < 12; i++) begin
      r = lfsr(r);
      REFRESH_REQ <= r[12];
      run(r[0], r[1], 1'b0, 1'b0, r[2] | r[5], r[3] | r[6], r[4], 4'h6 + {1'b0, r[10:8]});
    end
    wrap_up();
  end
  // A hang ends the run as a failure.
  initial begin
    #60000;
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
